// >>> hdl/plm_link_ctl.sv
// Link mode, crossover, status and management register logic
//
// Contract
// [R1] Forced 10/100 partner: parallel detect, half duplex
// [R2] Gigabit only both negotiating or forced opposite roles
// [R3] Negotiation off: role follows role-select setting
// [R4] System should keep negotiation enabled normally
// [R5] Crossover search pulses every 150 us
// [R6] Negotiation pulses every 125 us +/- 14 us; code sends them only with auto crossover off, else pulses every 150 us
// [R7] Aux bit 15 clear disables automatic crossover
// [R8] Aux bit 14 picks crossed or straight pairs
// [R9] Speed indicator needs selected speed and link
// [R10] Basic status link bit latches low until read
// [R11] Live register shows link, speed, duplex now
// [R12] Legacy mode by strap high or aux bit 9
// [R13] Activity on idle error or packet transfer
// [R14] Straps set initial configuration, no management needed
// [R15] Straps captured once at reset release
`timescale 1ns/1ns
module plm_link_ctl #(
  parameter int         XOVER_CYC = plm_pkg::XOVER_CYC,
  parameter int         FLP_CYC   = plm_pkg::FLP_CYC,
  parameter logic [4:0] PHY_ADDR  = 5'h01
) (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_b_in,
  // Management pins
  input  wire logic       mdc_in,
  input  wire logic       mdio_in,
  output logic            mdio_out,
  output logic            mdio_oe_b_out,
  // Strap pins
  input  wire logic       strap_neg_enable_in,
  input  wire logic       strap_role_master_in,
  input  wire logic       strap_legacy_in,
  // Line receiver status
  input  wire logic       partner_negotiating_in,
  input  wire logic [1:0] partner_speed_in,
  input  wire logic       partner_master_in,
  input  wire logic       rx_good_in,
  input  wire logic       idle_error_in,
  input  wire logic       packet_xfer_in,
  // Line pulses
  output logic            pulse_straight_out,
  output logic            pulse_crossed_out,
  output logic            pair_crossed_out,
  // Indicators and status
  output logic            led_10_out,
  output logic            led_100_out,
  output logic            led_1000_out,
  output logic            activity_out,
  output logic            link_up_out,
  output logic            role_master_out,
  output logic            legacy_mode_out
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  generate
    if (XOVER_CYC < 2 || FLP_CYC < 2) begin : g_bad_cyc
      $error("plm_link_ctl: pulse periods must be at least 2 cycles");
    end
  endgenerate

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0]      mdc_s_q, mdc_s_d, mdio_s_q, mdio_s_d;
  logic [2:0][2:0] strap_s_q, strap_s_d;
  logic            mdc_lvl_q, mdc_lvl_d, mdc_rise, mdio_bit;
  logic            mdio_lvl_q, mdio_lvl_d;

  // Three stages; a change counts once stages two and three agree
  always_comb begin
    mdc_s_d   = {mdc_s_q[1:0], mdc_in};
    mdio_s_d  = {mdio_s_q[1:0], mdio_in};
    strap_s_d = {strap_s_q[1:0],
                 {strap_legacy_in, strap_role_master_in,
                  strap_neg_enable_in}};
    mdc_lvl_d = (mdc_s_q[1] == mdc_s_q[2]) ? mdc_s_q[2] : mdc_lvl_q;
    mdc_rise  = mdc_lvl_d && !mdc_lvl_q;
    mdio_lvl_d = (mdio_s_q[1] == mdio_s_q[2]) ? mdio_s_q[2] : mdio_lvl_q;
    mdio_bit  = mdio_lvl_d;
  end

  // Synchroniser registers
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mdc_s_q    <= '1;                 // High idle: no false rise
      mdio_s_q   <= '1;
      strap_s_q  <= '0;
      mdc_lvl_q  <= 1'b1;
      mdio_lvl_q <= 1'b1;
    end else begin
      mdc_s_q    <= mdc_s_d;
      mdio_s_q   <= mdio_s_d;
      strap_s_q  <= strap_s_d;
      mdc_lvl_q  <= mdc_lvl_d;
      mdio_lvl_q <= mdio_lvl_d;
    end
  end

  // ----------------------------------------------------------------
  // Configuration: strap capture and auxiliary control
  // ----------------------------------------------------------------
  plm_pkg::plm_aux_t aux_q, aux_d;
  logic [1:0]        strap_cnt_q, strap_cnt_d;
  logic              strap_done_q, strap_done_d;
  logic              strap_leg_q, strap_leg_d;
  logic              wr_stb;
  logic [4:0]        addr_q;
  logic [15:0]       wr_data;
  logic [15:0]       sr_q;

  assign wr_data = {sr_q[14:0], mdio_bit};

  // Straps land once after release, then writes may override
  always_comb begin
    aux_d        = aux_q;
    strap_cnt_d  = strap_cnt_q;
    strap_done_d = strap_done_q;
    strap_leg_d  = strap_leg_q;
    if (!strap_done_q) begin
      if (strap_cnt_q != plm_pkg::STRAP_WAIT) begin
        strap_cnt_d = strap_cnt_q + 2'h1;
      end else if (strap_s_q[1] == strap_s_q[2]) begin
        strap_done_d     = 1'b1;                              // R15
        aux_d.neg_en     = strap_s_q[2][0];                   // R14
        aux_d.role_master = strap_s_q[2][1];                  // R14
        strap_leg_d      = strap_s_q[2][2];                   // R14
      end
    end else if (wr_stb && addr_q == plm_pkg::REG_AUX_CONF) begin
      aux_d      = plm_pkg::plm_aux_t'(wr_data);
      aux_d.rsvd = '0;
    end
  end

  // Configuration registers
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      aux_q        <= plm_pkg::plm_aux_t'(plm_pkg::AUX_RST);
      strap_cnt_q  <= '0;
      strap_done_q <= 1'b0;
      strap_leg_q  <= 1'b0;
    end else begin
      aux_q        <= aux_d;
      strap_cnt_q  <= strap_cnt_d;
      strap_done_q <= strap_done_d;
      strap_leg_q  <= strap_leg_d;
    end
  end

  chk_strap_capture: assert property ( // R15
    $rose(strap_done_q) |-> aux_q.neg_en == $past(strap_s_q[2][0]))
    else $error("strap not captured at release");

  // ----------------------------------------------------------------
  // Link resolution, indicators and status
  // ----------------------------------------------------------------
  plm_pkg::plm_link_t st_q, st_d;
  logic               ok;
  logic               lat_q, lat_d, act_q, act_d, leg_q, leg_d;
  logic [2:0]         led_q, led_d;
  logic               rd_basic_stb;

  // Resolve speed, duplex and role against the partner
  always_comb begin
    ok          = 1'b0;
    st_d        = st_q;
    st_d.master = aux_q.role_master;                          // R3
    if (aux_q.neg_en) begin
      if (partner_negotiating_in) begin
        ok            = 1'b1;                                 // R2
        st_d.speed    = plm_pkg::SPD_1000;
        st_d.full_dup = 1'b1;
        st_d.master   = !partner_master_in;
      end else if (partner_speed_in == plm_pkg::SPD_10 ||
                   partner_speed_in == plm_pkg::SPD_100) begin
        ok            = 1'b1;                                 // R1
        st_d.speed    = partner_speed_in;
        st_d.full_dup = 1'b0;
      end
    end else begin
      st_d.speed    = aux_q.forced_speed;
      st_d.full_dup = (aux_q.forced_speed == plm_pkg::SPD_1000);
      ok = !partner_negotiating_in &&
           partner_speed_in == aux_q.forced_speed &&
           aux_q.forced_speed != plm_pkg::SPD_NONE &&
           (aux_q.forced_speed != plm_pkg::SPD_1000 ||
            aux_q.role_master != partner_master_in);           // R2
    end
    st_d.link = ok && rx_good_in;
    // Indicator is speed AND good link
    led_d[0] = st_d.link && st_d.speed == plm_pkg::SPD_10;    // R9
    led_d[1] = st_d.link && st_d.speed == plm_pkg::SPD_100;   // R9
    led_d[2] = st_d.link && st_d.speed == plm_pkg::SPD_1000;  // R9
    // Loss wins over the re-arm of a read in the same cycle
    lat_d = rd_basic_stb ? st_q.link : (lat_q && st_q.link);  // R10
    act_d = st_q.link && (idle_error_in || packet_xfer_in);   // R13
    leg_d = strap_leg_q || aux_q.legacy;                      // R12
  end

  // Link state registers
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_q  <= '0;
      lat_q <= 1'b0;
      act_q <= 1'b0;
      leg_q <= 1'b0;
      led_q <= '0;
    end else begin
      st_q  <= st_d;
      lat_q <= lat_d;
      act_q <= act_d;
      leg_q <= leg_d;
      led_q <= led_d;
    end
  end

  assign led_10_out      = led_q[0];
  assign led_100_out     = led_q[1];
  assign led_1000_out    = led_q[2];
  assign activity_out    = act_q;
  assign link_up_out     = st_q.link;
  assign role_master_out = st_q.master;
  assign legacy_mode_out = leg_q;

  chk_par_det_half: assert property ( // R1
    (aux_q.neg_en && !partner_negotiating_in && rx_good_in &&
     partner_speed_in == plm_pkg::SPD_100)
    |=> (st_q.link && st_q.speed == plm_pkg::SPD_100 && !st_q.full_dup))
    else $error("parallel detect did not give 100 half duplex");
  chk_no_par_gig: assert property ( // R2
    (aux_q.neg_en && !partner_negotiating_in &&
     partner_speed_in == plm_pkg::SPD_1000) |=> !link_up_out)
    else $error("gigabit link came up by parallel detect");
  chk_forced_role: assert property ( // R3
    !aux_q.neg_en |=> role_master_out == $past(aux_q.role_master))
    else $error("forced role does not follow role select");
  chk_led_gig_link: assert property ( // R9
    led_1000_out |-> (link_up_out && st_q.speed == plm_pkg::SPD_1000))
    else $error("gigabit indicator without gigabit link");
  chk_link_latch_low: assert property ( // R10
    (!st_q.link && !rd_basic_stb)
    |=> !lat_q ##1 (!lat_q || $past(rd_basic_stb)))
    else $error("latched link bit did not hold low");
  chk_legacy_mode: assert property ( // R12
    (strap_done_q && aux_q.legacy) |=> legacy_mode_out)
    else $error("legacy mode not entered from control bit");
  chk_activity_led: assert property ( // R13
    (link_up_out && packet_xfer_in) |=> activity_out)
    else $error("activity not shown on packet transfer");

  // ----------------------------------------------------------------
  // Crossover control and link pulses
  // ----------------------------------------------------------------
  logic x_en, f_en, x_tick, f_tick;
  logic pair_q, pair_d, pst_q, pst_d, pcr_q, pcr_d;

  assign x_en = aux_q.auto_xover && !st_q.link;                       // R5
  assign f_en = !aux_q.auto_xover && aux_q.neg_en && !st_q.link;      // R6

  plm_tick_gen #(.PERIOD(XOVER_CYC)) u_xover_tick (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .en_in    (x_en),
    .tick_out (x_tick)
  );

  plm_tick_gen #(.PERIOD(FLP_CYC)) u_flp_tick (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .en_in    (f_en),
    .tick_out (f_tick)
  );

  // Auto search hops pairs per pulse; manual mode uses bit 14
  always_comb begin
    if (!aux_q.auto_xover) begin
      pair_d = aux_q.cross_sel;                               // R7 R8
    end else begin
      pair_d = pair_q ^ x_tick;
    end
    pst_d = (x_tick || f_tick) && !pair_d;                    // R8
    pcr_d = (x_tick || f_tick) && pair_d;                     // R8
  end

  // Pulse registers
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pair_q <= 1'b0;
      pst_q  <= 1'b0;
      pcr_q  <= 1'b0;
    end else begin
      pair_q <= pair_d;
      pst_q  <= pst_d;
      pcr_q  <= pcr_d;
    end
  end

  assign pulse_straight_out = pst_q;
  assign pulse_crossed_out  = pcr_q;
  assign pair_crossed_out   = pair_q;

  // Gap counters between ticks, read only by checks
  int xgap_q, fgap_q;
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      xgap_q <= 0;
      fgap_q <= 0;
    end else begin
      xgap_q <= !x_en ? 0 : (x_tick ? 1 : (xgap_q == 0 ? 0 : xgap_q + 1));
      fgap_q <= !f_en ? 0 : (f_tick ? 1 : (fgap_q == 0 ? 0 : fgap_q + 1));
    end
  end

  chk_xover_period: assert property ( // R5
    (x_tick && xgap_q != 0) |-> xgap_q == XOVER_CYC)
    else $error("crossover pulse period wrong");
  chk_flp_period: assert property ( // R6
    (f_tick && fgap_q != 0) |-> fgap_q == FLP_CYC)
    else $error("negotiation pulse period wrong");
  chk_manual_pair: assert property ( // R8
    !aux_q.auto_xover |=> pair_crossed_out == $past(aux_q.cross_sel))
    else $error("manual pair selection not applied");

  // ----------------------------------------------------------------
  // Management serial slave
  // ----------------------------------------------------------------
  plm_pkg::plm_mstate_t ms_q, ms_d;
  logic [5:0]  cnt_q, cnt_d;
  logic [15:0] sr_d;
  logic [4:0]  addr_d;
  logic        rd_op_q, rd_op_d, mo_q, mo_d, moe_b_q, moe_b_d;
  logic [12:0] hv;
  logic        hdr_ok;

  // Register read view
  function automatic logic [15:0] rd_mux(input logic [4:0] a);
    logic [15:0] v;
    v = '0;
    if (a == plm_pkg::REG_BASIC_STAT) begin
      v[plm_pkg::BS_NEG_ABLE_BIT] = 1'b1;
      v[plm_pkg::BS_LINK_BIT]     = lat_q;                    // R10
    end else if (a == plm_pkg::REG_LIVE_STAT) begin
      v[plm_pkg::LS_LINK_BIT]     = st_q.link;                // R11
      v[plm_pkg::LS_FDX_BIT]      = st_q.full_dup;
      v[plm_pkg::LS_MASTER_BIT]   = st_q.master;
      v[plm_pkg::LS_SPD_LSB +: 2] = st_q.speed;
    end else if (a == plm_pkg::REG_AUX_CONF) begin
      v = 16'(aux_q);
    end
    return v;
  endfunction

  assign hv     = {sr_q[11:0], mdio_bit};
  assign hdr_ok = hv[12] && hv[9:5] == PHY_ADDR;

  // Frame walk: preamble, header, turnaround, data
  always_comb begin
    ms_d    = ms_q;
    cnt_d   = cnt_q;
    sr_d    = sr_q;
    addr_d  = addr_q;
    rd_op_d = rd_op_q;
    mo_d    = mo_q;
    moe_b_d = moe_b_q;
    wr_stb = 1'b0;
    rd_basic_stb = 1'b0;
    if (mdc_rise) begin
      unique case (ms_q)
        plm_pkg::MS_PRE: begin
          if (mdio_bit) begin
            if (cnt_q != plm_pkg::PRE_ONES) cnt_d = cnt_q + 6'h01;
          end else begin
            cnt_d = '0;
            if (cnt_q == plm_pkg::PRE_ONES) ms_d = plm_pkg::MS_HDR;
          end
        end
        plm_pkg::MS_HDR: begin
          sr_d  = {sr_q[14:0], mdio_bit};
          cnt_d = cnt_q + 6'h01;
          if (cnt_q[3:0] == plm_pkg::HDR_LAST) begin
            cnt_d  = '0;
            addr_d = hv[4:0];
            ms_d   = plm_pkg::MS_PRE;
            if (hdr_ok && hv[11:10] == plm_pkg::OP_RD) begin
              ms_d         = plm_pkg::MS_TA;
              rd_op_d      = 1'b1;
              sr_d         = rd_mux(hv[4:0]);
              rd_basic_stb = hv[4:0] == plm_pkg::REG_BASIC_STAT;  // R10
            end else if (hdr_ok && hv[11:10] == plm_pkg::OP_WR) begin
              ms_d    = plm_pkg::MS_TA;
              rd_op_d = 1'b0;
            end
          end
        end
        plm_pkg::MS_TA: begin
          cnt_d = cnt_q + 6'h01;
          if (cnt_q == 6'h00) begin
            if (rd_op_q) begin
              moe_b_d = 1'b0;
              mo_d    = 1'b0;
            end
          end else begin
            cnt_d = '0;
            ms_d  = rd_op_q ? plm_pkg::MS_RD : plm_pkg::MS_WR;
            if (rd_op_q) begin
              mo_d = sr_q[15];
              sr_d = {sr_q[14:0], 1'b0};
            end
          end
        end
        plm_pkg::MS_RD: begin
          cnt_d = cnt_q + 6'h01;
          if (cnt_q[3:0] == plm_pkg::DAT_LAST) begin
            cnt_d   = '0;
            ms_d    = plm_pkg::MS_PRE;
            moe_b_d = 1'b1;
            mo_d    = 1'b1;
          end else begin
            mo_d = sr_q[15];
            sr_d = {sr_q[14:0], 1'b0};
          end
        end
        plm_pkg::MS_WR: begin
          sr_d  = wr_data;
          cnt_d = cnt_q + 6'h01;
          if (cnt_q[3:0] == plm_pkg::DAT_LAST) begin
            cnt_d  = '0;
            ms_d   = plm_pkg::MS_PRE;
            wr_stb = 1'b1;
          end
        end
        default: ms_d = plm_pkg::MS_PRE;
      endcase
    end
  end

  // Management registers
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ms_q    <= plm_pkg::MS_PRE;
      cnt_q   <= '0;
      sr_q    <= '0;
      addr_q  <= '0;
      rd_op_q <= 1'b0;
      mo_q    <= 1'b1;
      moe_b_q <= 1'b1;
    end else begin
      ms_q    <= ms_d;
      cnt_q   <= cnt_d;
      sr_q    <= sr_d;
      addr_q  <= addr_d;
      rd_op_q <= rd_op_d;
      mo_q    <= mo_d;
      moe_b_q <= moe_b_d;
    end
  end

  assign mdio_out      = mo_q;
  assign mdio_oe_b_out = moe_b_q;

endmodule

// >>> inc/plm_pkg.sv
// Shared constants, register layout and types for the link control block
package plm_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 10;
  localparam int XOVER_PERIOD_NS = 150000;   // Crossover search pulses
  localparam int FLP_PERIOD_NS   = 125000;   // Negotiation pulses, +/-14 us
  localparam int XOVER_CYC       = XOVER_PERIOD_NS / CLK_PERIOD_NS;
  localparam int FLP_CYC         = FLP_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [1:0] STRAP_WAIT = 2'h3;  // Cycles before strap capture

  // ----------------------------------------------------------------
  // Register map (management register numbers)
  // ----------------------------------------------------------------
  localparam logic [4:0] REG_BASIC_STAT = 5'h01;
  localparam logic [4:0] REG_LIVE_STAT  = 5'h11;
  localparam logic [4:0] REG_AUX_CONF   = 5'h12;

  // Basic status bit positions
  localparam int BS_LINK_BIT      = 2;
  localparam int BS_NEG_ABLE_BIT  = 3;
  // Live status bit positions
  localparam int LS_MASTER_BIT    = 0;
  localparam int LS_FDX_BIT       = 1;
  localparam int LS_LINK_BIT      = 2;
  localparam int LS_SPD_LSB       = 3;

  // Auxiliary control value after reset, before straps land
  localparam logic [15:0] AUX_RST = 16'h8000;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] SPD_10   = 2'h0;
  localparam logic [1:0] SPD_100  = 2'h1;
  localparam logic [1:0] SPD_1000 = 2'h2;
  localparam logic [1:0] SPD_NONE = 2'h3;
  localparam logic [1:0] OP_WR    = 2'h1;
  localparam logic [1:0] OP_RD    = 2'h2;
  localparam logic [5:0] PRE_ONES = 6'h20;
  localparam logic [3:0] HDR_LAST = 4'hc;
  localparam logic [3:0] DAT_LAST = 4'hf;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       auto_xover;    // 15
    logic       cross_sel;     // 14
    logic       neg_en;        // 13
    logic       role_master;   // 12
    logic [1:0] forced_speed;  // 11:10
    logic       legacy;        // 9
    logic [8:0] rsvd;          // 8:0
  } plm_aux_t;

  typedef struct packed {
    logic       link;
    logic       full_dup;
    logic       master;
    logic [1:0] speed;
  } plm_link_t;

  typedef enum logic [4:0] {
    MS_PRE = 5'h01,
    MS_HDR = 5'h02,
    MS_TA  = 5'h04,
    MS_RD  = 5'h08,
    MS_WR  = 5'h10
  } plm_mstate_t;

endpackage

// >>> hdl/plm_tick_gen.sv
// Periodic one-cycle tick generator with enable
`timescale 1ns/1ns
module plm_tick_gen #(
  parameter int PERIOD = 16
) (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rst_b_in,
  // Control and tick
  input  wire logic en_in,
  output logic      tick_out
);
  localparam int W = (PERIOD > 2) ? $clog2(PERIOD) : 1;

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  generate
    if (PERIOD < 2) begin : g_bad_period
      $error("plm_tick_gen: PERIOD must be at least 2");
    end
  endgenerate

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  // Count while enabled, restart whenever disabled
  always_comb begin
    tick_out = en_in && (cnt_q == W'(PERIOD - 1));
    if (!en_in || tick_out) begin
      cnt_d = '0;
    end else begin
      cnt_d = cnt_q + W'(1);
    end
  end

  // Counter register
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule

// >>> tb/plm_partner.sv
// Remote link partner model driving the line receiver status
`timescale 1ns/1ns
module plm_partner (
  // Commanded partner behaviour
  input  wire logic       neg_in,
  input  wire logic [1:0] spd_in,
  input  wire logic       mst_in,
  input  wire logic       good_in,
  // Line view seen by the device
  output logic            neg_out,
  output logic [1:0]      spd_out,
  output logic            mst_out,
  output logic            good_out
);
  // A negotiating partner shows no forced speed
  always_comb begin
    neg_out  = neg_in;
    spd_out  = neg_in ? plm_pkg::SPD_NONE : spd_in;
    mst_out  = mst_in;
    good_out = good_in;
  end
endmodule

// >>> tb/tb.sv
// Self-checking bench for the link control block
`timescale 1ns/1ns
module tb;
  // Bench drive, straps and partner commands
  logic clk_in = 0, rst_b_in = 0, mdc = 0, md = 1, ie = 0, pk = 0;
  logic s_neg = 1, s_role = 1, s_leg = 0, p_neg = 1, p_mst = 1, p_good = 1;
  logic [1:0] p_spd = 2'h3, w_spd;
  logic w_neg, w_mst, w_good, mdo, oe_b, ps, pc, pcr;
  logic l10, l100, l1k, act, lu, rm, lg, a, b;
  logic [15:0] rd;
  plm_pkg::plm_aux_t ax = plm_pkg::AUX_RST;
  int error_cnt = 0, checks_done = 0, cyc = 0, seed = 32'h882dc764;
  int pt[$];
  logic pq[$];
  // Shared management line: bench drive unless the device output is enabled
  wire mdio = oe_b ? md : mdo;
  plm_partner plm_partner_i (.neg_in(p_neg), .spd_in(p_spd), .mst_in(p_mst),
    .good_in(p_good), .neg_out(w_neg), .spd_out(w_spd), .mst_out(w_mst),
    .good_out(w_good));
  plm_link_ctl #(.XOVER_CYC(20), .FLP_CYC(16)) plm_link_ctl_i (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .mdc_in(mdc), .mdio_in(mdio),
    .mdio_out(mdo), .mdio_oe_b_out(oe_b), .strap_neg_enable_in(s_neg),
    .strap_role_master_in(s_role), .strap_legacy_in(s_leg),
    .partner_negotiating_in(w_neg), .partner_speed_in(w_spd),
    .partner_master_in(w_mst), .rx_good_in(w_good), .idle_error_in(ie),
    .packet_xfer_in(pk), .pulse_straight_out(ps), .pulse_crossed_out(pc),
    .pair_crossed_out(pcr), .led_10_out(l10), .led_100_out(l100),
    .led_1000_out(l1k), .activity_out(act), .link_up_out(lu),
    .role_master_out(rm), .legacy_mode_out(lg));
  // Clock
  initial forever #5 clk_in = ~clk_in;
  // Cycle count, pulse log and hang guard
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (ps | pc) begin
      pt.push_back(cyc);
      pq.push_back(pc);
    end
    if (cyc == 90000) begin
      error_cnt++;
      end_of_test();
    end
  end
  task end_of_test;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input string n, input logic [15:0] g, e);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  // One management bit: data set on MDC fall, sampled before the rise
  task automatic mb(input logic v, output logic r);
    @(posedge clk_in);
    mdc <= 0;
    md <= v;
    repeat (8) @(posedge clk_in);
    r = mdio;
    mdc <= 1;
    repeat (8) @(posedge clk_in);
  endtask
  task automatic mf(input logic [1:0] op, input logic [4:0] ra,
                    input logic [15:0] wd, output logic [15:0] r16);
    logic [45:0] h;
    logic r;
    h = {32'hffffffff, 2'h1, op, 5'h01, ra};
    for (int i = 45; i >= 0; i--) mb(h[i], r);
    mb(1, r);
    mb(op != plm_pkg::OP_WR, r);
    for (int i = 15; i >= 0; i--) begin
      mb(op == plm_pkg::OP_WR ? wd[i] : 1'h1, r);
      r16[i] = r;
    end
  endtask
  task rr(input logic [4:0] ra);
    mf(plm_pkg::OP_RD, ra, 0, rd);
  endtask
  // Write auxiliary control with random reserved bits, read it back
  task wa();
    ax.rsvd = 9'($random(seed));
    mf(plm_pkg::OP_WR, plm_pkg::REG_AUX_CONF, ax, rd);
    rr(plm_pkg::REG_AUX_CONF);
    chk("aux", rd, {ax[15:9], 9'h0});
  endtask
  task sp(input logic n, input logic [1:0] s, input logic m, g);
    @(posedge clk_in);
    p_neg <= n;
    p_spd <= s;
    p_mst <= m;
    p_good <= g;
  endtask
  // Expected live status {speed, link, full duplex, master}
  function automatic logic [4:0] el();
    logic [1:0] s;
    logic f, m;
    s = plm_pkg::SPD_NONE;
    f = 0;
    m = ax.role_master;
    if (ax.neg_en && p_neg) begin
      s = plm_pkg::SPD_1000;
      f = 1;
      m = !p_mst;
    end else if (ax.neg_en && p_spd < plm_pkg::SPD_1000) s = p_spd;
    else if (!ax.neg_en && !p_neg && p_spd == ax.forced_speed &&
             (p_spd != plm_pkg::SPD_1000 || m != p_mst)) begin
      s = p_spd;
      f = s == plm_pkg::SPD_1000;
    end
    return {s, p_good && s != plm_pkg::SPD_NONE, f, m};
  endfunction
  task automatic ck();
    logic [4:0] e, k;
    repeat (6) @(posedge clk_in);
    e = el();
    k = !e[2] ? 5'h04 : (ax.neg_en && e[4:3] != 2'h2) ? 5'h1e : 5'h1f;
    chk("link", lu, e[2]);
    chk("leds", {l1k, l100, l10}, e[2] ? 3'h1 << e[4:3] : 3'h0);
    if (k[0]) chk("role", rm, e[0]);
    rr(plm_pkg::REG_LIVE_STAT);
    chk("live", rd & k, e & k);
  endtask
  task automatic pchk(input int per, input logic au, c);
    pt.delete();
    pq.delete();
    repeat (3 * per + 2) @(posedge clk_in);
    #1;
    chk("npulse", pt.size() >= 2, 1);
    if (pt.size() >= 2) begin
      chk("period", pt[1] - pt[0], per);
      chk("pair", pq[1], au ? !pq[0] : c);
    end
  endtask
  // Main sequence
  initial begin
    repeat (5) @(posedge clk_in);
    chk("rst", {lu, oe_b, mdo}, 3'h3);
    repeat (7) @(posedge clk_in);
    rst_b_in <= 1;
    repeat (10) @(posedge clk_in);
    ax.neg_en = 1;
    ax.role_master = 1;
    rr(plm_pkg::REG_AUX_CONF);
    chk("aux_strap", rd, ax);
    chk("legacy", lg, 0);
    $display("reset test done");
    for (int i = 0; i < 4; i++) begin
      sp(i == 3, 2'(i), 1, 1);
      ck();
    end
    $display("negotiation test done");
    ax.neg_en = 0;
    ax.forced_speed = plm_pkg::SPD_1000;
    wa();
    for (int i = 0; i < 4; i++) begin
      sp(i == 3, i == 2 ? 2'h1 : 2'h2, i == 0, 1);
      ck();
    end
    ax.forced_speed = plm_pkg::SPD_100;
    wa();
    sp(0, 1, 0, 1);
    ck();
    $display("forced test done");
    rr(plm_pkg::REG_BASIC_STAT);
    rr(plm_pkg::REG_BASIC_STAT);
    chk("bstat", rd[3:2], 2'h3);
    sp(0, 1, 0, 0);
    repeat (4) @(posedge clk_in);
    sp(0, 1, 0, 1);
    repeat (6) @(posedge clk_in);
    chk("link_now", lu, 1);
    rr(plm_pkg::REG_BASIC_STAT);
    chk("bstat_lost", rd[3:2], 2'h2);
    rr(plm_pkg::REG_BASIC_STAT);
    chk("bstat_back", rd[3:2], 2'h3);
    $display("latch test done");
    for (int i = 0; i < 8; i++) begin
      {a, b} = 2'($random(seed));
      @(posedge clk_in);
      pk <= a;
      ie <= b;
      @(posedge clk_in);
      pk <= 0;
      ie <= 0;
      #1;
      chk("act", act, a | b);
    end
    $display("activity test done");
    sp(0, 3, 0, 0);
    ax.neg_en = 1;
    wa();
    pchk(20, 1, 0);
    ax.auto_xover = 0;
    for (int i = 0; i < 2; i++) begin
      ax.cross_sel = i[0];
      wa();
      pchk(16, 0, i[0]);
      chk("pair_out", pcr, i[0]);
    end
    $display("pulse test done");
    ax.legacy = 1;
    wa();
    chk("legacy_reg", lg, 1);
    @(posedge clk_in);
    rst_b_in <= 0;
    {s_neg, s_role, s_leg} <= 3'h1;
    repeat (12) @(posedge clk_in);
    rst_b_in <= 1;
    repeat (10) @(posedge clk_in);
    s_leg <= 0;
    repeat (4) @(posedge clk_in);
    chk("legacy_strap", lg, 1);
    rr(plm_pkg::REG_AUX_CONF);
    chk("aux_strap2", rd, plm_pkg::AUX_RST);
    $display("strap test done");
    end_of_test();
  end
endmodule
